// file: timer_pkg.sv
// constants, register map and carrier types of the timer channel block
// assumes a byte-wide register per aligned ahb-lite word
package timer_pkg;
  localparam int NCH = 2;
  // ==================================================
  // register map, byte addresses
  localparam logic [7:0] A_TSC = 8'h00;
  localparam logic [7:0] A_CNTH = 8'h04;
  localparam logic [7:0] A_CNTL = 8'h08;
  localparam logic [7:0] A_MODH = 8'h0c;
  localparam logic [7:0] A_MODL = 8'h10;
  localparam logic [7:0] A_CH0 = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] O_CSC = 8'h00;
  localparam logic [7:0] O_VH = 8'h04;
  localparam logic [7:0] O_VL = 8'h08;
  // ==================================================
  // field positions
  localparam int TSC_CAS = 0;
  localparam int TSC_RUN = 3;
  localparam int TSC_OIE = 6;
  localparam int TSC_OVF = 7;
  localparam int CSC_ELSA = 2;
  localparam int CSC_ELSB = 3;
  localparam int CSC_MSA = 4;
  localparam int CSC_MSB = 5;
  localparam int CSC_IE = 6;
  localparam int CSC_FLG = 7;
  // ==================================================
  // values
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] ELS_TOG = 2'h1;
  localparam logic [1:0] ELS_CLR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;
endpackage

// file: timer_channels.sv
// timer counter, modulus and capture/compare/pwm channels behind ahb-lite
// assumes one master, single word transfers; capture pins are synchronous
//
// Behaviour
// R1: selected pin edge copies counter into value
// R2: capture byte read freezes both halves
// R3: channel control write resets read coherency
// R4: capture event sets channel flag
// R5: compare match sets, clears or toggles pin
// R6: compare value loads after both bytes written
// R7: compare match sets channel flag
// R8: edge pwm: up count, modulus period, value duty
// R9: edge pwm: overflow high, match low, polarity inverts
// R10: value zero 0%, above modulus 100%
// R11: edge pwm reload at counter zero
// R12: center pwm width and period doubled
// R13: center pwm zero or negative value 0%
// R14: software keeps center modulus 1 to 7ffe
// R15: zero modulus runs counter free to ffff
// R16: center pwm: up match low, down high
// R17: center pwm reload at counter reversal
// R18: all pwm buffers update together; the code loads the edge pwm modulus as soon as both bytes are written
// R19: control writes discard pending byte writes
// R20: flag on counter match or capture edge
// R21: level interrupt while flag and enable set
// R22: read-then-write-0 clear, new event wins
// R23: center select forces up/down, all channels
// R24: overflow at wrap or at top reversal
`timescale 1ns/100ps
module timer_channels
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [timer_pkg::NCH-1:0] ch_in,
  output logic [timer_pkg::NCH-1:0] ch_out,
  output logic [timer_pkg::NCH-1:0] ch_oe,
  output logic ovf_irq,
  output logic [timer_pkg::NCH-1:0] ch_irq
);
  localparam int N = timer_pkg::NCH;

  function automatic logic ch_hit(input logic [7:0] a, input int n, input logic [7:0] o);
    ch_hit = (a == 8'(timer_pkg::A_CH0 + 8'(n) * timer_pkg::CH_STRIDE + o));
  endfunction

  // ==================================================
  // bus slave
  timer_pkg::ahb_req_t req_reg;
  logic [31:0] rdata_next;
  wire take = hsel && htrans[1] && hready;
  wire rd = take && !hwrite;
  wire [7:0] raddr = haddr[7:0];
  wire wr = req_reg.valid && req_reg.write;
  wire [7:0] waddr = req_reg.addr;
  wire [7:0] wd = hwdata[7:0];

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      req_reg <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= timer_pkg::RESP_OKAY;
    end
    else
    begin
      req_reg <= '{take, hwrite, raddr};
      hrdata <= rd ? rdata_next : '0;
      hreadyout <= 1'b1;
      hresp <= timer_pkg::RESP_OKAY;
    end
  end

  // ==================================================
  // counter and modulus
  logic [15:0] cnt_reg, cnt_next, mod_reg, modbuf_reg;
  logic mod_hw_reg, mod_lw_reg, down_reg, down_next;
  logic cas_reg, run_reg, oie_reg, ovf_reg, ovf_arm_reg;
  wire tick = run_reg;
  wire [15:0] term = (mod_reg == timer_pkg::CNT_ZERO) ? timer_pkg::CNT_FULL : mod_reg; // R15
  wire tsc_wr = wr && waddr == timer_pkg::A_TSC;
  wire cnt_wr = wr && (waddr == timer_pkg::A_CNTH || waddr == timer_pkg::A_CNTL);
  wire ovf_evt = tick && !cnt_wr && (cas_reg ? (!down_reg && cnt_reg == mod_reg) : cnt_reg == term); // R24
  wire ovf_clr = tsc_wr && !wd[timer_pkg::TSC_OVF] && ovf_arm_reg;

  always_comb
  begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    if (cnt_wr)
    begin
      cnt_next = timer_pkg::CNT_ZERO;
      down_next = 1'b0;
    end
    else if (tick && !cas_reg)
      cnt_next = (cnt_reg == term) ? timer_pkg::CNT_ZERO : cnt_reg + timer_pkg::CNT_ONE; // R8
    else if (tick && !down_reg)
    begin
      // up/down count; top and zero each last one tick
      if (cnt_reg == mod_reg) // R23
      begin
        down_next = 1'b1;
        cnt_next = cnt_reg - timer_pkg::CNT_ONE;
      end
      else
        cnt_next = cnt_reg + timer_pkg::CNT_ONE;
    end
    else if (tick)
    begin
      if (cnt_reg == timer_pkg::CNT_ZERO)
      begin
        down_next = 1'b0;
        cnt_next = timer_pkg::CNT_ONE;
      end
      else
        cnt_next = cnt_reg - timer_pkg::CNT_ONE;
    end
  end

  wire mod_both = mod_hw_reg && mod_lw_reg;
  // center mode holds the new period back to the reversal
  wire mod_load = mod_both && (!cas_reg || ovf_evt); // R17 R18

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cnt_reg <= timer_pkg::CNT_ZERO;
      down_reg <= 1'b0;
      mod_reg <= timer_pkg::CNT_ZERO;
      modbuf_reg <= timer_pkg::CNT_ZERO;
      mod_hw_reg <= 1'b0;
      mod_lw_reg <= 1'b0;
      cas_reg <= 1'b0;
      run_reg <= 1'b0;
      oie_reg <= 1'b0;
      ovf_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
      ovf_irq <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      down_reg <= down_next;
      if (tsc_wr)
      begin
        cas_reg <= wd[timer_pkg::TSC_CAS];
        run_reg <= wd[timer_pkg::TSC_RUN];
        oie_reg <= wd[timer_pkg::TSC_OIE];
      end
      if (wr && waddr == timer_pkg::A_MODH)
        modbuf_reg[15:8] <= wd;
      if (wr && waddr == timer_pkg::A_MODL)
        modbuf_reg[7:0] <= wd;
      if (tsc_wr || mod_load) // R19
      begin
        mod_hw_reg <= 1'b0;
        mod_lw_reg <= 1'b0;
      end
      else
      begin
        mod_hw_reg <= mod_hw_reg || (wr && waddr == timer_pkg::A_MODH);
        mod_lw_reg <= mod_lw_reg || (wr && waddr == timer_pkg::A_MODL);
      end
      if (mod_load)
        mod_reg <= modbuf_reg;
      ovf_reg <= ovf_evt || (ovf_reg && !ovf_clr); // R22
      ovf_arm_reg <= !ovf_evt && !ovf_clr && (ovf_arm_reg || (rd && raddr == timer_pkg::A_TSC && ovf_reg));
      ovf_irq <= oie_reg && (ovf_evt || (ovf_reg && !ovf_clr)); // R21
    end
  end

  // ==================================================
  // channels
  logic [15:0] cv_reg [N];
  logic [15:0] vbuf_reg [N];
  logic [15:0] rlat_reg [N];
  logic [6:2] csc_reg [N];
  logic [N-1:0] vhw_reg, vlw_reg, rl_reg, rlhi_reg, flg_reg, arm_reg, pin_reg;
  logic [N-1:0] cap, cmp, epwm, evt, clr, load, csc_wr, vh_rd, vl_rd, lvl;
  logic [15:0] cvn [N];

  always_comb
  begin
    for (int n = 0; n < N; n++)
    begin
      cap[n] = !cas_reg && csc_reg[n][5:4] == 2'h0;
      cmp[n] = !cas_reg && csc_reg[n][5:4] == 2'h1;
      epwm[n] = !cas_reg && csc_reg[n][timer_pkg::CSC_MSB];
      csc_wr[n] = wr && ch_hit(waddr, n, timer_pkg::O_CSC);
      vh_rd[n] = rd && ch_hit(raddr, n, timer_pkg::O_VH);
      vl_rd[n] = rd && ch_hit(raddr, n, timer_pkg::O_VL);
      // edge select: 01 rising, 10 falling, 11 either
      evt[n] = cap[n] ? ((csc_reg[n][2] && ch_in[n] && !pin_reg[n]) ||
                         (csc_reg[n][3] && !ch_in[n] && pin_reg[n])) // R1 R4
                      : (tick && cnt_reg == cv_reg[n]); // R7 R20
      clr[n] = csc_wr[n] && !wd[timer_pkg::CSC_FLG] && arm_reg[n];
      // all pwm value reloads share one boundary; the edge pwm modulus loads as soon as both bytes are written
      load[n] = vhw_reg[n] && vlw_reg[n] && (cmp[n] ||
                (epwm[n] && tick && cnt_next == timer_pkg::CNT_ZERO) || // R11 R18
                (cas_reg && ovf_evt)); // R17
      // a reloaded value counts from the first cycle of its period
      cvn[n] = load[n] ? vbuf_reg[n] : cv_reg[n];
      // high while below value: overflow raises, match drops
      // center: the down match raises, so that count is high too and the width is twice the value
      lvl[n] = cas_reg ? (cvn[n] != timer_pkg::CNT_ZERO && !cvn[n][15] &&
                          (down_next ? cnt_next <= cvn[n] : cnt_next < cvn[n])) // R12 R13 R16
                       : (cnt_next < cvn[n]); // R9 R10
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int n = 0; n < N; n++)
      begin
        cv_reg[n] <= timer_pkg::CNT_ZERO;
        vbuf_reg[n] <= timer_pkg::CNT_ZERO;
        rlat_reg[n] <= timer_pkg::CNT_ZERO;
        csc_reg[n] <= '0;
      end
      {vhw_reg, vlw_reg, rl_reg, rlhi_reg} <= '0;
      {flg_reg, arm_reg, pin_reg, ch_out, ch_oe, ch_irq} <= '0;
    end
    else
    begin
      pin_reg <= ch_in;
      for (int n = 0; n < N; n++)
      begin
        if (csc_wr[n])
          csc_reg[n] <= wd[6:2];
        if (wr && ch_hit(waddr, n, timer_pkg::O_VH))
          vbuf_reg[n][15:8] <= wd;
        if (wr && ch_hit(waddr, n, timer_pkg::O_VL))
          vbuf_reg[n][7:0] <= wd;
        if (csc_wr[n] || load[n]) // R19
        begin
          vhw_reg[n] <= 1'b0;
          vlw_reg[n] <= 1'b0;
        end
        else
        begin
          vhw_reg[n] <= vhw_reg[n] || (wr && ch_hit(waddr, n, timer_pkg::O_VH));
          vlw_reg[n] <= vlw_reg[n] || (wr && ch_hit(waddr, n, timer_pkg::O_VL));
        end
        if (cap[n] && evt[n])
          cv_reg[n] <= cnt_reg; // R1
        else if (load[n])
          cv_reg[n] <= vbuf_reg[n]; // R6
        // first byte read freezes the pair until the other byte is read
        if (csc_wr[n])
          rl_reg[n] <= 1'b0; // R3
        else if (cap[n] && !rl_reg[n] && (vh_rd[n] || vl_rd[n]))
        begin
          rl_reg[n] <= 1'b1; // R2
          rlhi_reg[n] <= vh_rd[n];
          rlat_reg[n] <= cv_reg[n];
        end
        else if (rl_reg[n] && ((vh_rd[n] && !rlhi_reg[n]) || (vl_rd[n] && rlhi_reg[n])))
          rl_reg[n] <= 1'b0;
        flg_reg[n] <= evt[n] || (flg_reg[n] && !clr[n]); // R22
        arm_reg[n] <= !evt[n] && !clr[n] && (arm_reg[n] || (rd && ch_hit(raddr, n, timer_pkg::O_CSC) && flg_reg[n]));
        ch_irq[n] <= csc_reg[n][timer_pkg::CSC_IE] && (evt[n] || (flg_reg[n] && !clr[n])); // R21
        ch_oe[n] <= !cap[n] && (cas_reg || epwm[n] || csc_reg[n][3:2] != 2'h0);
        if (cas_reg || epwm[n])
          ch_out[n] <= lvl[n] ^ csc_reg[n][timer_pkg::CSC_ELSA]; // R9
        else if (cmp[n] && evt[n])
        begin
          case (csc_reg[n][3:2]) // R5
            timer_pkg::ELS_TOG: ch_out[n] <= !ch_out[n];
            timer_pkg::ELS_CLR: ch_out[n] <= 1'b0;
            timer_pkg::ELS_SET: ch_out[n] <= 1'b1;
            default: ch_out[n] <= ch_out[n];
          endcase
        end
      end
    end
  end

  // ==================================================
  // read data
  always_comb
  begin
    rdata_next = '0;
    if (raddr == timer_pkg::A_TSC)
      rdata_next[7:0] = {ovf_reg, oie_reg, 2'h0, run_reg, 2'h0, cas_reg};
    else if (raddr == timer_pkg::A_CNTH)
      rdata_next[7:0] = cnt_reg[15:8];
    else if (raddr == timer_pkg::A_CNTL)
      rdata_next[7:0] = cnt_reg[7:0];
    else if (raddr == timer_pkg::A_MODH)
      rdata_next[7:0] = mod_reg[15:8];
    else if (raddr == timer_pkg::A_MODL)
      rdata_next[7:0] = mod_reg[7:0];
    for (int n = 0; n < N; n++)
    begin
      if (ch_hit(raddr, n, timer_pkg::O_CSC))
        rdata_next[7:0] = {flg_reg[n], csc_reg[n], 2'h0};
      else if (ch_hit(raddr, n, timer_pkg::O_VH))
        rdata_next[7:0] = rl_reg[n] ? rlat_reg[n][15:8] : cv_reg[n][15:8];
      else if (ch_hit(raddr, n, timer_pkg::O_VL))
        rdata_next[7:0] = rl_reg[n] ? rlat_reg[n][7:0] : cv_reg[n][7:0];
    end
  end

  // ==================================================
  // checks on the counter and on channels 0 and 1
  property p_capture;
    @(posedge mclk) disable iff (!rstn)
    (cap[1] && evt[1]) |=> cv_reg[1] == $past(cnt_reg);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // R1

  property p_csc_reset;
    @(posedge mclk) disable iff (!rstn)
    csc_wr[0] |=> !vhw_reg[0] && !vlw_reg[0] && !rl_reg[0];
  endproperty
  a_csc_reset: assert property (p_csc_reset) else $error("coherency not reset"); // R3

  property p_cmp_load;
    @(posedge mclk) disable iff (!rstn)
    (cmp[0] && vhw_reg[0] && vlw_reg[0] && !csc_wr[0]) |=> cv_reg[0] == $past(vbuf_reg[0]);
  endproperty
  a_cmp_load: assert property (p_cmp_load) else $error("compare value not loaded"); // R6

  property p_ovf_set;
    @(posedge mclk) disable iff (!rstn)
    ovf_evt |=> ovf_reg ##0 cnt_reg == ($past(cas_reg) ? $past(mod_reg) - timer_pkg::CNT_ONE : timer_pkg::CNT_ZERO);
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag or count wrong"); // R24

  property p_hold;
    @(posedge mclk) disable iff (!rstn)
    (evt[0] && csc_wr[0] && !wd[timer_pkg::CSC_FLG]) |=> flg_reg[0];
  endproperty
  a_hold: assert property (p_hold) else $error("event lost in clear"); // R22

  property p_irq;
    @(posedge mclk) disable iff (!rstn)
    (flg_reg[1] && csc_reg[1][timer_pkg::CSC_IE] && !csc_wr[1]) |=> ch_irq[1];
  endproperty
  a_irq: assert property (p_irq) else $error("channel request dropped"); // R21

  property p_zero_duty;
    @(posedge mclk) disable iff (!rstn)
    (epwm[0] && cvn[0] == timer_pkg::CNT_ZERO && !csc_wr[0]) |=> ch_out[0] == $past(csc_reg[0][timer_pkg::CSC_ELSA]);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty not held"); // R10

  property p_cpwm_neg;
    @(posedge mclk) disable iff (!rstn)
    (cas_reg && cvn[0][15] && !csc_wr[0] && !tsc_wr) |=> ch_out[0] == csc_reg[0][timer_pkg::CSC_ELSA];
  endproperty
  a_cpwm_neg: assert property (p_cpwm_neg) else $error("negative value not 0 duty"); // R13

  property p_cas_drive;
    @(posedge mclk) disable iff (!rstn)
    cas_reg |=> (&ch_oe);
  endproperty
  a_cas_drive: assert property (p_cas_drive) else $error("center mode channel not driving"); // R23

  property p_free_run;
    @(posedge mclk) disable iff (!rstn)
    (tick && !cas_reg && !cnt_wr && mod_reg == timer_pkg::CNT_ZERO && cnt_reg == timer_pkg::CNT_FULL)
      |=> cnt_reg == timer_pkg::CNT_ZERO;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run wrap wrong"); // R15
endmodule

// file: pins_model.sv
// outside pin model: level sources on the capture pins of the timer block
// assumes the bench sets the wanted levels; a channel that drives wins the pin
`timescale 1ns/100ps
module pins_model
(
  input wire logic mclk,
  input wire logic [1:0] drive,
  input wire logic [1:0] ch_out,
  input wire logic [1:0] ch_oe,
  output logic [1:0] ch_in
);
  // ====================
  // pin resolution
  // levels move only on a clock edge so no runt pulse reaches the capture logic
  always_ff @(posedge mclk)
    ch_in <= (ch_oe & ch_out) | (~ch_oe & drive);
endmodule

// file: test_timer_channels.sv
// bench for the timer channel block: ahb-lite master, pwm, compare and capture
// assumes pins_model on the capture pins and a single slave on the bus
`timescale 1ns/100ps
module test_timer_channels;
  localparam logic [7:0] TSC = timer_pkg::A_TSC;
  localparam logic [7:0] C0 = timer_pkg::A_CH0;
  localparam logic [7:0] C1 = timer_pkg::A_CH0 + timer_pkg::CH_STRIDE;
  localparam logic [7:0] VH = timer_pkg::O_VH;
  localparam logic [7:0] VL = timer_pkg::O_VL;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic [1:0] drive = 2'h0;
  logic [1:0] ch_in;
  logic [1:0] ch_out;
  logic [1:0] ch_oe;
  logic ovf_irq;
  logic [1:0] ch_irq;
  logic [31:0] seed = 32'h38;
  logic [7:0] q;
  logic [15:0] m;
  logic [15:0] v;
  logic [15:0] c;
  logic [16:0] hc;
  logic e;
  int n_mismatch = 0;
  int comparisons = 0;
  always #10 mclk = ~mclk;
  timer_channels uut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe),
    .ovf_irq(ovf_irq), .ch_irq(ch_irq));
  pins_model pins (.mclk(mclk), .drive(drive), .ch_out(ch_out), .ch_oe(ch_oe), .ch_in(ch_in));
  // ====================
  // expectations
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // high cycles in one full period
  function automatic logic [16:0] duty(input logic [15:0] x, input logic cas, input logic pol);
    logic [16:0] h;
    logic [16:0] n;
    n = cas ? {m, 1'b0} : {1'b0, m} + 17'h1;
    if (cas)
      h = (x[15] || x == 16'h0) ? 17'h0 : (x > m) ? n : {x, 1'b0};
    else
      h = (x > m) ? n : {1'b0, x};
    return pol ? n - h : h;
  endfunction
  // ====================
  // reporting
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic guard(inout int k);
    k++;
    if (k > 200)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] x, input logic [7:0] g);
    comparisons++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk_cnt(input string nm, input logic [16:0] x, input logic [16:0] g);
    comparisons++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // ====================
  // bus master
  task automatic rdy();
    int k;
    k = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      guard(k);
      @(posedge mclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy();
    q = hrdata[7:0];
  endtask
  // byte order drawn at random; either order must land
  task automatic wv(input logic [7:0] b, input logic [15:0] x);
    seed = xs(seed);
    if (seed[0])
      bus(1'b1, b + VH, x[15:8]);
    bus(1'b1, b + VL, x[7:0]);
    if (!seed[0])
      bus(1'b1, b + VH, x[15:8]);
  endtask
  task automatic wait_flag(input logic [7:0] a);
    int k;
    k = 0;
    bus(1'b0, a, 8'h00);
    while (q[7] !== 1'b1)
    begin
      guard(k);
      bus(1'b0, a, 8'h00);
    end
  endtask
  task automatic rdcnt(output logic [15:0] x);
    bus(1'b0, timer_pkg::A_CNTH, 8'h00);
    x[15:8] = q;
    bus(1'b0, timer_pkg::A_CNTL, 8'h00);
    x[7:0] = q;
  endtask
  task automatic edge_in();
    drive <= drive ^ 2'h2;
    repeat (4) @(posedge mclk);
  endtask
  // two periods for the reload, then one whole period counted
  task automatic meas(input int n);
    repeat (2 * n) @(posedge mclk);
    hc = 17'h0;
    repeat (n)
    begin
      @(posedge mclk);
      hc = hc + ch_out[0];
    end
  endtask
  task automatic pwm(input logic cas, input int i);
    logic pol;
    pol = i[0];
    seed = xs(seed);
    v = (i == 0) ? 16'h0 : (i == 1 && cas) ? {1'b1, seed[14:0]} : (i < 3) ? m + 16'h1 : seed[15:0] % m;
    bus(1'b1, C0, pol ? 8'h24 : 8'h28);
    wv(C0, v);
    meas(cas ? 2 * m : m + 1);
    chk_cnt("pwm duty", duty(v, cas, pol), hc);
  endtask
  // ====================
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, TSC, 8'h00);
    chk_reg("tsc reset", 8'h00, q);
    chk_reg("hresp", 8'h00, {6'h0, hresp});
    seed = xs(seed);
    m = {10'h0, seed[5:0]} + 16'h20;
    bus(1'b1, timer_pkg::A_MODH, 8'h00);
    bus(1'b1, timer_pkg::A_MODL, m[7:0]);
    bus(1'b1, TSC, 8'h08);
    bus(1'b1, C1, 8'h4c);
    for (int i = 0; i < 4; i++)
      pwm(1'b0, i);
    // a control write between the two bytes throws the first away
    c = v;
    v = c ^ 16'h0001;
    bus(1'b1, C0 + VL, v[7:0]);
    bus(1'b1, C0, 8'h24);
    bus(1'b1, C0 + VH, v[15:8]);
    meas(m + 1);
    chk_cnt("discarded byte", duty(c, 1'b0, 1'b1), hc);
    bus(1'b1, C0 + VL, v[7:0]);
    meas(m + 1);
    chk_cnt("both bytes", duty(v, 1'b0, 1'b1), hc);
    e = 1'b1;
    for (int i = 3; i > 0; i--)
    begin
      seed = xs(seed);
      // the read arms the clear that the control write below carries out
      bus(1'b0, C0, 8'h00);
      bus(1'b1, C0, {2'h0, 2'h1, i[1:0], 2'h0});
      wv(C0, seed[15:0] % m);
      wait_flag(C0);
      e = ch_out[0];
      repeat (m + 1) @(posedge mclk);
      chk_reg("compare pin", {6'h0, 1'b1, (i == 1) ? ~e : (i == 3)}, {6'h0, ch_oe[0], ch_out[0]});
    end
    bus(1'b1, TSC, 8'h48);
    repeat (m + 2) @(posedge mclk);
    chk_reg("ovf irq", 8'h01, {7'h0, ovf_irq});
    bus(1'b1, TSC, 8'h40);
    bus(1'b0, TSC, 8'h00);
    chk_reg("ovf flag", 8'hc0, q);
    bus(1'b1, TSC, 8'h40);
    bus(1'b0, TSC, 8'h00);
    chk_reg("ovf clear", 8'h40, q);
    bus(1'b1, C1, 8'h4c);
    rdcnt(c);
    edge_in();
    bus(1'b0, C1 + VH, 8'h00);
    chk_reg("capture high", c[15:8], q);
    bus(1'b1, TSC, 8'h08);
    repeat (7) @(posedge mclk);
    bus(1'b1, TSC, 8'h00);
    rdcnt(v);
    edge_in();
    bus(1'b0, C1 + VL, 8'h00);
    chk_reg("capture low held", c[7:0], q);
    bus(1'b0, C1 + VH, 8'h00);
    chk_reg("capture new", v[15:8], q);
    bus(1'b0, C1, 8'h00);
    chk_reg("capture flag", 8'hcc, q);
    chk_reg("capture irq", 8'h01, {7'h0, ch_irq[1]});
    // an event between the read and the write keeps the flag
    edge_in();
    bus(1'b1, C1, 8'h4c);
    bus(1'b0, C1, 8'h00);
    chk_reg("flag kept", 8'hcc, q);
    bus(1'b1, C1, 8'h4c);
    bus(1'b0, C1, 8'h00);
    chk_reg("flag cleared", 8'h4c, q);
    chk_reg("irq cleared", 8'h00, {7'h0, ch_irq[1]});
    bus(1'b1, TSC, 8'h09);
    for (int i = 0; i < 4; i++)
      pwm(1'b1, i);
    chk_reg("forced pwm", 8'h01, {7'h0, ch_oe[1]});
    wrap_up();
  end
endmodule
